// ==== pkg/optcfg_cfg.svh ====
// option latch addresses, field positions, reset values and recovery counts
`ifndef OPTCFG_CFG_SVH
`define OPTCFG_CFG_SVH

// register indexes; byte address is four times the index
`define OPT_IDX_ONE 16'h001D
`define OPT_IDX_TWO 16'h001F
`define OPT_IDX_OSC 16'hFFCF

// reset and erased values
`define OPT_ONE_RESET 8'h00
`define OPT_TWO_RESET 8'h00
`define OPT_OSC_ERASED 8'hFF
`define OPT_RDATA_ZERO 32'h0000_0000

// writable bits of the second option register (bits 2:1 reserved)
`define OPT_TWO_MASK 8'hF9

// first option register fields
`define OPT_B1_RATE 7
`define OPT_B1_MONITOR_IN_STOP_ON 6
`define OPT_B1_LVIRST 5
`define OPT_B1_VDDOFF 4
`define OPT_B1_VREGOFF 3
`define OPT_B1_SHORT_STOP_RECOVERY 2
`define OPT_B1_STOPEN 1
`define OPT_B1_WDOFF 0

// second option register fields
`define OPT_B2_ICLKOFF 7
`define OPT_B2_RCRUN 6
`define OPT_B2_XRUN 5
`define OPT_B2_TICK_HI 4
`define OPT_B2_TICK_LO 3
`define OPT_B2_BAUD 0

// oscillator option byte fields
`define OPT_BO_SEL_HI 7
`define OPT_BO_SEL_LO 6

// source codes
`define OPT_TICK_INT 2'b00
`define OPT_TICK_RC 2'b01
`define OPT_TICK_XTAL 2'b10
`define OPT_MAIN_INT 2'b01
`define OPT_MAIN_RC 2'b10
`define OPT_MAIN_XTAL 2'b11

// stop recovery lengths in internal oscillator cycles
`define OPT_SHORT_REC_CYC 32
`define OPT_LONG_REC_CYC 4096

`endif

// ==== pkg/optcfg_pkg.sv ====
// types shared by the option latch block
package optcfg_pkg;
   // gray order along run, stop, recover
   typedef enum logic [1:0] {
      OPT_RUN = 2'b00,
      OPT_STOPPED = 2'b01,
      OPT_RECOVER = 2'b11
   } optcfg_state_type;

   // register selector decoded from the bus address
   typedef enum logic [1:0] {
      OPT_SEL_NONE = 2'b00,
      OPT_SEL_ONE = 2'b01,
      OPT_SEL_TWO = 2'b10,
      OPT_SEL_OSC = 2'b11
   } optcfg_sel_type;
endpackage

// ==== hdl/optcfg_sync.sv ====
// three-stage synchroniser with a rising-edge pulse
`timescale 1ns/100ps
module optcfg_sync (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // asynchronous level
   input wire logic pin_in,
   // one-cycle pulse on a settled rise
   output logic rise
);
   logic s1;
   logic s2;
   logic s3;
   logic stable;

   // first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // a change counts once stages two and three agree
   // settled level starts high, but the stages reset low, so a pin already high at release still gives one rise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stable <= 1'b1;
         rise <= 1'b0;
      end else begin
         rise <= (s2 == s3) && s2 && !stable;
         if (s2 == s3) begin
            stable <= s2;
         end
      end
   end
endmodule // optcfg_sync

// ==== hdl/optcfg_recovery.sv ====
// stop-mode recovery counter on the bus clock, counting internal oscillator ticks
`timescale 1ns/100ps
`include "optcfg_cfg.svh"
module optcfg_recovery #(
   parameter int SHORT_CYC = `OPT_SHORT_REC_CYC,
   parameter int LONG_CYC = `OPT_LONG_REC_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire logic start,
   input wire logic use_short,
   input wire logic osc_tick,
   // status
   output logic busy,
   output logic done
);
   logic [12:0] count;

   // reset itself always starts a long recovery
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 13'(LONG_CYC);
         busy <= 1'b1;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            count <= use_short ? 13'(SHORT_CYC) : 13'(LONG_CYC);
            busy <= 1'b1;
         end else if (busy && osc_tick) begin
            if (count == 13'h0001) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 13'h0001;
            end
         end
      end
   end
endmodule // optcfg_recovery

// ==== hdl/optcfg_top.sv ====
// option latches, oscillator option byte and stop control behind AHB-Lite
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "optcfg_cfg.svh"
module optcfg_top #(
   parameter int SHORT_CYC = `OPT_SHORT_REC_CYC,
   parameter int LONG_CYC = `OPT_LONG_REC_CYC
) (
   // bus clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // flash side of the option byte
   input wire logic por_n,
   input wire logic osc_byte_prog,
   input wire logic [7:0] osc_byte_data,
   input wire logic osc_byte_erase,
   // core and monitor events
   input wire logic stop_insn,
   input wire logic wake_event,
   input wire logic lvi_reset_req,
   input wire logic internal_osc_clock_pin,
   // monitor and watchdog controls
   output logic vreg_lvi_enable,
   output logic vdd_lvi_enable,
   output logic lvi_stop_enable,
   output logic lvi_reset_out,
   output logic watchdog_enable,
   output logic watchdog_short_rate,
   // stop control
   output logic stop_illegal,
   output logic stop_mode,
   output logic cpu_clock_run,
   // oscillator enables
   output logic int_osc_run,
   output logic rc_osc_run,
   output logic crystal_osc_run,
   // clock routing selects
   output logic tick_from_int,
   output logic tick_from_rc,
   output logic tick_from_xtal,
   output logic serial_from_bus,
   output logic main_from_int,
   output logic main_from_rc,
   output logic main_from_xtal,
   output logic osc_out_bus,
   output logic osc_out_xtal_inv
);
   logic [7:0] system_option_one;
   logic [7:0] system_option_two;
   logic [7:0] oscillator_option_byte;
   logic one_locked;
   logic two_locked;
   logic wr_pend;
   logic rd_pend;
   optcfg_pkg::optcfg_sel_type wr_sel;
   optcfg_pkg::optcfg_sel_type rd_sel;
   optcfg_pkg::optcfg_state_type state;
   optcfg_pkg::optcfg_state_type next_state;
   logic addr_ok;
   logic internal_osc_clock_tick;
   logic rec_start;
   logic rec_busy;
   logic rec_done;
   logic [1:0] tick_code;
   logic [1:0] main_code;
   logic stopped;

   // decode a word address into a register selector
   function automatic optcfg_pkg::optcfg_sel_type decode(input logic [31:0] a);
      optcfg_pkg::optcfg_sel_type s;
      s = optcfg_pkg::OPT_SEL_NONE;
      if (a[31:18] == 14'h0000 && a[1:0] == 2'b00) begin
         if (a[17:2] == `OPT_IDX_ONE) begin
            s = optcfg_pkg::OPT_SEL_ONE;
         end else if (a[17:2] == `OPT_IDX_TWO) begin
            s = optcfg_pkg::OPT_SEL_TWO;
         end else if (a[17:2] == `OPT_IDX_OSC) begin
            s = optcfg_pkg::OPT_SEL_OSC;
         end
      end
      return s;
   endfunction

   // read value of a selected register, zero when unmapped
   function automatic logic [7:0] read_value(
      input optcfg_pkg::optcfg_sel_type s,
      input logic [7:0] one,
      input logic [7:0] two,
      input logic [7:0] osc
   );
      logic [7:0] v;
      v = 8'h00;
      unique case (s)
         optcfg_pkg::OPT_SEL_ONE: v = one;
         optcfg_pkg::OPT_SEL_TWO: v = two;
         optcfg_pkg::OPT_SEL_OSC: v = osc;
         optcfg_pkg::OPT_SEL_NONE: v = 8'h00;
      endcase
      return v;
   endfunction

   // a transfer is taken only in a real address phase
   assign addr_ok = hsel && hready && htrans[1];

   // bus address phase; reads take one wait state so data come from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_sel <= optcfg_pkg::OPT_SEL_NONE;
         rd_sel <= optcfg_pkg::OPT_SEL_NONE;
      end else begin
         wr_pend <= addr_ok && hwrite;
         rd_pend <= addr_ok && !hwrite;
         if (addr_ok) begin
            wr_sel <= decode(haddr);
            rd_sel <= decode(haddr);
         end
      end
   end

   // bus answer; always OKAY, reads complete one cycle late
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= `OPT_RDATA_ZERO;
      end else begin
         hresp <= 1'b0;
         if (addr_ok && !hwrite) begin
            hreadyout <= 1'b0;
         end else if (rd_pend) begin
            hreadyout <= 1'b1;
            hrdata <= {24'h000000,
               read_value(rd_sel, system_option_one, system_option_two,
                  oscillator_option_byte)};
         end
      end
   end

   // first option register: one write per reset, later writes dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_option_one <= `OPT_ONE_RESET;
         one_locked <= 1'b0;
      end else if (wr_pend && wr_sel == optcfg_pkg::OPT_SEL_ONE && !one_locked) begin
         system_option_one <= hwdata[7:0];
         one_locked <= 1'b1;
      end
   end

   // second option register, reserved bits held at zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         system_option_two <= `OPT_TWO_RESET;
         two_locked <= 1'b0;
      end else if (wr_pend && wr_sel == optcfg_pkg::OPT_SEL_TWO && !two_locked) begin
         system_option_two <= hwdata[7:0] & `OPT_TWO_MASK;
         two_locked <= 1'b1;
      end
   end

   // option byte lives in flash: only power-on, erase and programming touch it
   // a bus write to it is ignored, and system reset leaves it alone
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         oscillator_option_byte <= `OPT_OSC_ERASED;
      end else if (osc_byte_erase) begin
         oscillator_option_byte <= `OPT_OSC_ERASED;
      end else if (osc_byte_prog) begin
         // programming can only pull bits toward zero
         oscillator_option_byte <= oscillator_option_byte & osc_byte_data;
      end
   end

   // internal oscillator ticks arrive from another clock
   optcfg_sync u_internal_osc_clock_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(internal_osc_clock_pin),
      .rise(internal_osc_clock_tick)
   );

   // recovery counter; busy from reset release
   optcfg_recovery #(
      .SHORT_CYC(SHORT_CYC),
      .LONG_CYC(LONG_CYC)
   ) u_recovery (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(rec_start),
      .use_short(system_option_one[`OPT_B1_SHORT_STOP_RECOVERY]),
      .osc_tick(internal_osc_clock_tick),
      .busy(rec_busy),
      .done(rec_done)
   );

   // stop sequencing; a stop with the enable clear goes nowhere
   always_comb begin
      next_state = state;
      rec_start = 1'b0;
      unique case (state)
         optcfg_pkg::OPT_RUN: begin
            if (stop_insn && system_option_one[`OPT_B1_STOPEN]) begin
               next_state = optcfg_pkg::OPT_STOPPED;
            end
         end
         optcfg_pkg::OPT_STOPPED: begin
            if (wake_event) begin
               next_state = optcfg_pkg::OPT_RECOVER;
               rec_start = 1'b1;
            end
         end
         optcfg_pkg::OPT_RECOVER: begin
            if (rec_done || !rec_busy) begin
               next_state = optcfg_pkg::OPT_RUN;
            end
         end
         default: begin
            next_state = optcfg_pkg::OPT_RECOVER;
         end
      endcase
   end

   // reset lands in recovery so the long delay runs after it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= optcfg_pkg::OPT_RECOVER;
      end else begin
         state <= next_state;
      end
   end

   // stop status outputs and the illegal-opcode pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_illegal <= 1'b0;
         stop_mode <= 1'b0;
         cpu_clock_run <= 1'b0;
      end else begin
         stop_illegal <= state == optcfg_pkg::OPT_RUN && stop_insn
            && !system_option_one[`OPT_B1_STOPEN];
         stop_mode <= next_state == optcfg_pkg::OPT_STOPPED;
         cpu_clock_run <= next_state == optcfg_pkg::OPT_RUN;
      end
   end

   // field aliases for the decode below
   assign stopped = state == optcfg_pkg::OPT_STOPPED;
   assign tick_code = {system_option_two[`OPT_B2_TICK_HI],
      system_option_two[`OPT_B2_TICK_LO]};
   assign main_code = {oscillator_option_byte[`OPT_BO_SEL_HI],
      oscillator_option_byte[`OPT_BO_SEL_LO]};

   // monitor and watchdog controls
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vreg_lvi_enable <= 1'b1;
         vdd_lvi_enable <= 1'b1;
         lvi_stop_enable <= 1'b0;
         lvi_reset_out <= 1'b0;
         watchdog_enable <= 1'b1;
         watchdog_short_rate <= 1'b0;
      end else begin
         vreg_lvi_enable <= !system_option_one[`OPT_B1_VREGOFF];
         vdd_lvi_enable <= !system_option_one[`OPT_B1_VDDOFF];
         // in-stop monitor only while at least one monitor is on
         lvi_stop_enable <= system_option_one[`OPT_B1_MONITOR_IN_STOP_ON]
            && !(system_option_one[`OPT_B1_VDDOFF]
            && system_option_one[`OPT_B1_VREGOFF]);
         lvi_reset_out <= lvi_reset_req && !system_option_one[`OPT_B1_LVIRST];
         watchdog_enable <= !system_option_one[`OPT_B1_WDOFF];
         watchdog_short_rate <= system_option_one[`OPT_B1_RATE];
      end
   end

   // oscillator run enables; outside stop everything runs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_osc_run <= 1'b1;
         rc_osc_run <= 1'b1;
         crystal_osc_run <= 1'b1;
      end else begin
         int_osc_run <= !(stopped && system_option_two[`OPT_B2_ICLKOFF]);
         rc_osc_run <= !stopped || system_option_two[`OPT_B2_RCRUN];
         crystal_osc_run <= !stopped || system_option_two[`OPT_B2_XRUN];
      end
   end

   // tick and serial clock routing; code 11 selects no tick source
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_from_int <= 1'b1;
         tick_from_rc <= 1'b0;
         tick_from_xtal <= 1'b0;
         serial_from_bus <= 1'b0;
      end else begin
         tick_from_int <= tick_code == `OPT_TICK_INT;
         tick_from_rc <= tick_code == `OPT_TICK_RC;
         tick_from_xtal <= tick_code == `OPT_TICK_XTAL;
         serial_from_bus <= system_option_two[`OPT_B2_BAUD];
      end
   end

   // main oscillator and output pin routing; code 00 selects nothing
   // these follow the option byte, so system reset does not disturb them
   always_ff @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         main_from_int <= 1'b0;
         main_from_rc <= 1'b0;
         main_from_xtal <= 1'b1;
         osc_out_bus <= 1'b0;
         osc_out_xtal_inv <= 1'b1;
      end else begin
         main_from_int <= main_code == `OPT_MAIN_INT;
         main_from_rc <= main_code == `OPT_MAIN_RC;
         main_from_xtal <= main_code == `OPT_MAIN_XTAL;
         osc_out_bus <= main_code == `OPT_MAIN_INT || main_code == `OPT_MAIN_RC;
         osc_out_xtal_inv <= main_code == `OPT_MAIN_XTAL;
      end
   end
endmodule // optcfg_top

// ==== verification/optcfg_sva.sv ====
// concurrent checks on the option latch block ports
`timescale 1ns/100ps
module optcfg_sva #(
   parameter int SHORT_CYC = 32,
   parameter int LONG_CYC = 4096
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   // stop and monitor
   input wire logic stop_insn,
   input wire logic wake_event,
   input wire logic lvi_reset_req,
   input wire logic lvi_reset_out,
   input wire logic stop_illegal,
   input wire logic stop_mode,
   input wire logic cpu_clock_run,
   // clock routing
   input wire logic tick_from_int,
   input wire logic tick_from_rc,
   input wire logic tick_from_xtal,
   input wire logic main_from_int,
   input wire logic main_from_rc,
   input wire logic main_from_xtal,
   input wire logic osc_out_bus,
   input wire logic osc_out_xtal_inv
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
      !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
   chk_write_fast: assert property (hsel && hready && htrans[1] && hwrite |=>
      hreadyout) else $error("write stalled");
   chk_resp_okay: assert property (!hresp) else $error("error response");
   chk_stop_answer: assert property (cpu_clock_run && stop_insn |=>
      stop_mode != stop_illegal) else $error("stop not answered");
   chk_illegal_cause: assert property (stop_illegal |-> $past(stop_insn) && !stop_mode)
      else $error("stray illegal pulse");
   chk_run_stop: assert property (!(stop_mode && cpu_clock_run))
      else $error("clock runs in stop");
   chk_lvi_gate: assert property (lvi_reset_out |-> $past(lvi_reset_req))
      else $error("monitor reset without request");
   chk_stop_hold: assert property (stop_mode && !wake_event |=> stop_mode)
      else $error("stop left without wake");
   chk_wake_delay: assert property ($fell(stop_mode) |-> !cpu_clock_run [*8])
      else $error("recovery too short");
   chk_tick_onehot: assert property ($onehot0({tick_from_int, tick_from_rc, tick_from_xtal}))
      else $error("tick select not one-hot");
   chk_pin_route: assert property (osc_out_xtal_inv == main_from_xtal &&
      osc_out_bus == (main_from_int || main_from_rc)) else $error("output pin route wrong");
endmodule // optcfg_sva

bind optcfg_top optcfg_sva #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_sva (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .stop_insn(stop_insn),
   .wake_event(wake_event), .lvi_reset_req(lvi_reset_req), .lvi_reset_out(lvi_reset_out),
   .stop_illegal(stop_illegal), .stop_mode(stop_mode), .cpu_clock_run(cpu_clock_run),
   .tick_from_int(tick_from_int), .tick_from_rc(tick_from_rc), .tick_from_xtal(tick_from_xtal),
   .main_from_int(main_from_int), .main_from_rc(main_from_rc),
   .main_from_xtal(main_from_xtal), .osc_out_bus(osc_out_bus),
   .osc_out_xtal_inv(osc_out_xtal_inv));

// ==== verification/optcfg_cpu_model.sv ====
// bus master standing in for the core
`timescale 1ns/100ps
module optcfg_cpu_model (
   // clock
   input wire logic hclk,
   // bus return
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // bus request
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // idle bus, word size only
   initial begin
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // one single word; each phase held until hready is seen
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
endmodule // optcfg_cpu_model

// ==== verification/testbench.sv ====
// self-checking bench for the option latch block
`timescale 1ns/100ps
`include "optcfg_cfg.svh"
module testbench;
   localparam int LONG = 64;
   localparam logic [31:0] A_ONE = {14'h0, `OPT_IDX_ONE, 2'h0};
   localparam logic [31:0] A_TWO = {14'h0, `OPT_IDX_TWO, 2'h0};
   localparam logic [31:0] A_OSC = {14'h0, `OPT_IDX_OSC, 2'h0};
   logic hclk, hresetn, por_n, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic prog, erase, stop_insn, wake, lvi_req, internal_osc_clock;
   logic [7:0] pdata;
   logic vreg_en, vdd_en, lvi_stop_en, lvi_rst, wd_en, wd_rate, stop_ill, stop_mode, run;
   logic int_run, rc_run, x_run, t_int, t_rc, t_x, ser_bus, m_int, m_rc, m_x, o_bus, o_inv;
   logic [7:0] pv [4] = '{8'h7F, 8'hBF, 8'h00, 8'hBF};
   logic [7:0] ov [4] = '{8'h7F, 8'h3F, 8'hFF, 8'hBF};
   logic [7:0] rv [4] = '{8'h12, 8'h00, 8'h05, 8'h0A};
   int err_total, n_compared, rises;

   optcfg_cpu_model cpu (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   optcfg_top #(.SHORT_CYC(`OPT_SHORT_REC_CYC), .LONG_CYC(LONG)) uut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .por_n(por_n), .osc_byte_prog(prog), .osc_byte_data(pdata),
      .osc_byte_erase(erase), .stop_insn(stop_insn), .wake_event(wake),
      .lvi_reset_req(lvi_req), .internal_osc_clock_pin(internal_osc_clock), .vreg_lvi_enable(vreg_en),
      .vdd_lvi_enable(vdd_en), .lvi_stop_enable(lvi_stop_en), .lvi_reset_out(lvi_rst),
      .watchdog_enable(wd_en), .watchdog_short_rate(wd_rate), .stop_illegal(stop_ill),
      .stop_mode(stop_mode), .cpu_clock_run(run), .int_osc_run(int_run), .rc_osc_run(rc_run),
      .crystal_osc_run(x_run), .tick_from_int(t_int), .tick_from_rc(t_rc),
      .tick_from_xtal(t_x), .serial_from_bus(ser_bus), .main_from_int(m_int),
      .main_from_rc(m_rc), .main_from_xtal(m_x), .osc_out_bus(o_bus), .osc_out_xtal_inv(o_inv));

   // bus clock, and internal oscillator that halts while disabled
   always #25 hclk = ~hclk;
   always #250 internal_osc_clock = (int_run === 1'b0) ? internal_osc_clock : ~internal_osc_clock;
   always @(posedge internal_osc_clock) rises++;

   task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string msg);
      n_compared++;
      if (act !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // let registered outputs follow the latches
   task automatic settle;
      repeat (2) @(posedge hclk);
      #1;
   endtask
   task automatic pulse(input logic s, input logic w);
      @(posedge hclk);
      stop_insn <= s;
      wake <= w;
      @(posedge hclk);
      stop_insn <= 1'b0;
      wake <= 1'b0;
      #1;
   endtask
   // count oscillator rises until the core clock returns; sync latency allows one either way
   task automatic run_count(input int cyc);
      int n;
      rises = 0;
      n = 0;
      while (run !== 1'b1 && n < 5000) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, rises >= cyc - 1 && rises <= cyc + 1}, 32'h1, "recovery length");
   endtask
   task automatic reset_pulse;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      #1;
   endtask

   // hang guard well beyond the expected run
   initial begin
      repeat (30000) @(posedge hclk);
      err_total++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_sim();
   end

   initial begin
      {hclk, hresetn, por_n, prog, erase, stop_insn, wake, lvi_req, internal_osc_clock} = 9'h000;
      pdata = 8'hFF;
      err_total = 0;
      n_compared = 0;
      rises = 0;
      repeat (12) @(posedge hclk);
      por_n <= 1'b1;
      hresetn <= 1'b1;
      #1;
      chk({24'h0, vreg_en, vdd_en, wd_en, t_int, t_rc, t_x, m_x, o_inv}, 32'hF3, "reset outs");
      chk({31'h0, int_run}, 32'h1, "int osc after reset");
      run_count(LONG);
      lvi_req <= 1'b1;
      settle();
      chk({31'h0, lvi_rst}, 32'h1, "monitor reset passes");
      cpu.xfer(1'b0, A_ONE, 32'h0, rd);
      chk(rd, 32'h0, "opt1 reset");
      cpu.xfer(1'b0, A_OSC, 32'h0, rd);
      chk(rd, 32'hFF, "option byte erased");
      // both monitors off, so reset-off goes in with them
      cpu.xfer(1'b1, A_ONE, 32'hFD, rd);
      cpu.xfer(1'b1, A_ONE, 32'h0, rd);
      cpu.xfer(1'b1, A_TWO, 32'hFF, rd);
      cpu.xfer(1'b1, 32'h80, 32'hFF, rd);
      cpu.xfer(1'b1, A_OSC, 32'h0, rd);
      settle();
      chk({24'h0, vreg_en, vdd_en, wd_en, lvi_rst, t_int, t_rc, t_x, ser_bus}, 32'h1, "cfg outs");
      chk({30'h0, wd_rate, lvi_stop_en}, 32'h2, "rate set, stop monitor gated");
      cpu.xfer(1'b0, A_ONE, 32'h0, rd);
      chk(rd, 32'hFD, "opt1 write once");
      cpu.xfer(1'b0, A_TWO, 32'h0, rd);
      chk(rd, 32'hF9, "opt2 readback");
      cpu.xfer(1'b0, 32'h80, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      cpu.xfer(1'b0, A_OSC, 32'h0, rd);
      chk(rd, 32'hFF, "bus write to option byte");
      pulse(1'b1, 1'b0);
      chk({30'h0, stop_ill, stop_mode}, 32'h2, "stop refused");
      // flash programming keeps the low six bits at one
      for (int i = 0; i < 4; i++) begin
         @(posedge hclk);
         prog <= (i != 2);
         erase <= (i == 2);
         pdata <= pv[i];
         @(posedge hclk);
         {prog, erase} <= 2'h0;
         settle();
         chk({27'h0, m_int, m_rc, m_x, o_bus, o_inv}, {24'h0, rv[i]}, "main osc route");
         cpu.xfer(1'b0, A_OSC, 32'h0, rd);
         chk(rd, {24'h0, ov[i]}, "option byte value");
      end
      lvi_req <= 1'b0;
      reset_pulse();
      chk({27'h0, m_int, m_rc, m_x, o_bus, o_inv}, 32'h0A, "option byte kept");
      run_count(LONG);
      // short recovery only with on-chip oscillators
      cpu.xfer(1'b1, A_ONE, 32'h46, rd);
      cpu.xfer(1'b1, A_TWO, 32'hA8, rd);
      settle();
      chk({27'h0, int_run, rc_run, x_run, t_rc, ser_bus}, 32'h1E, "run outs");
      chk({30'h0, wd_rate, lvi_stop_en}, 32'h1, "stop monitor on");
      pulse(1'b1, 1'b0);
      chk({29'h0, stop_mode, run, stop_ill}, 32'h4, "stop taken");
      settle();
      chk({29'h0, int_run, rc_run, x_run}, 32'h1, "stop osc");
      pulse(1'b0, 1'b1);
      run_count(`OPT_SHORT_REC_CYC);
      pulse(1'b1, 1'b0);
      reset_pulse();
      run_count(LONG);
      end_sim();
   end
endmodule // testbench
